// ### vec_pkg.sv
package vec_pkg;

    localparam int VEC_W = 256;
    localparam int HALF_W = 128;
    localparam int NUM_VREG = 16;
    localparam int VREG_AW = 4;
    localparam int DW_W = 32;
    localparam int QW_W = 64;
    localparam int ADDR_W = 64;
    localparam int NUM_DW = VEC_W / DW_W;
    localparam int NUM_QW = VEC_W / QW_W;

    // element counts of a gather, by vector length and widest element
    localparam logic [3:0] GATH_N_128_NARROW = 4'h4;
    localparam logic [3:0] GATH_N_128_WIDE = 4'h2;
    localparam logic [3:0] GATH_N_256_NARROW = 4'h8;
    localparam logic [3:0] GATH_N_256_WIDE = 4'h4;

    // identification query
    localparam logic [31:0] ID_LEAF_EXT_FEAT = 32'h0000_0007;
    localparam logic [31:0] ID_SUBLEAF_MAIN = 32'h0000_0000;
    localparam int ID_FEAT_BIT = 5;
    localparam logic [31:0] ID_EBX_NONE = 32'h0000_0000;

    // register file contents after reset
    localparam logic [VEC_W-1:0] VREG_RST = '0;

    typedef enum logic [4:0] {
        OP_LOAD,
        VAR_SHL_DWORD,
        VAR_SHL_QWORD,
        VAR_SAR_DWORD,
        VAR_SHR_DWORD,
        VAR_SHR_QWORD,
        PERM_INT32_INDEXED,
        PERM_INT64_IMMEDIATE,
        PERM_FP64_IMMEDIATE,
        PERM_FP32_INDEXED,
        GATHER_I32IDX_I32,
        GATHER_I64IDX_I32,
        GATHER_I32IDX_FP64,
        GATHER_I64IDX_FP64,
        GATHER_I32IDX_FP32,
        GATHER_I64IDX_FP32,
        GATHER_I32IDX_I64,
        GATHER_I64IDX_I64
    } vop_t;

endpackage

// ### vector_permute_shift_gather.sv
`timescale 1ns/1ps

module vector_permute_shift_gather
    import vec_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_SRST,
    input wire logic I_OP_VALID,
    input wire vop_t I_OP_CODE,
    input wire logic I_OP_NEWPFX,
    input wire logic I_OP_VL256,
    input wire logic [VREG_AW-1:0] I_OP_DST,
    input wire logic [VREG_AW-1:0] I_OP_SRC1,
    input wire logic [VREG_AW-1:0] I_OP_SRC2,
    input wire logic [VREG_AW-1:0] I_OP_MASK,
    input wire logic [7:0] I_OP_IMM,
    input wire logic [ADDR_W-1:0] I_OP_BASE,
    input wire logic [1:0] I_OP_SCALE,
    input wire logic [VEC_W-1:0] I_OP_DATA,
    output logic O_OP_READY,
    output logic O_OP_DONE,
    output logic [VEC_W-1:0] O_RES_DATA,
    output logic O_MEM_REQ,
    output logic [ADDR_W-1:0] O_MEM_ADDR,
    output logic O_MEM_SIZE64,
    input wire logic I_MEM_ACK,
    input wire logic [QW_W-1:0] I_MEM_DATA,
    input wire logic I_ID_REQ,
    input wire logic [31:0] I_ID_LEAF,
    input wire logic [31:0] I_ID_SUBLEAF,
    output logic O_ID_VALID,
    output logic [31:0] O_ID_EBX,
    input wire logic I_XS_REQ,
    input wire logic I_XS_WRITE,
    input wire logic [VREG_AW-1:0] I_XS_IDX,
    input wire logic [HALF_W-1:0] I_XS_WDATA,
    output logic O_XS_VALID,
    output logic [HALF_W-1:0] O_XS_RDATA
);

    typedef enum logic [0:0] {
        S_IDLE,
        S_GATHER
    } st_t;

    typedef struct packed {
        logic [NUM_VREG-1:0][VEC_W-1:0] rf;
        st_t st;
        vop_t op;
        logic newpfx;
        logic vl256;
        logic [VREG_AW-1:0] dst;
        logic [VREG_AW-1:0] idx_reg;
        logic [VREG_AW-1:0] mask_reg;
        logic [ADDR_W-1:0] base;
        logic [1:0] scale;
        logic [3:0] elem;
        logic [VEC_W-1:0] gacc;
        logic ready;
        logic done;
        logic [VEC_W-1:0] res;
        logic mem_req;
        logic [ADDR_W-1:0] mem_addr;
        logic mem_size64;
        logic id_valid;
        logic [31:0] id_ebx;
        logic xs_valid;
        logic [HALF_W-1:0] xs_rdata;
    } state_t;

    state_t q;
    state_t d;

    logic [VEC_W-1:0] src1;
    logic [VEC_W-1:0] src2;
    logic [NUM_DW-1:0][DW_W-1:0] shl_d;
    logic [NUM_DW-1:0][DW_W-1:0] shr_d;
    logic [NUM_DW-1:0][DW_W-1:0] sar_d;
    logic [NUM_DW-1:0][DW_W-1:0] perm_d;
    logic [NUM_QW-1:0][QW_W-1:0] shl_q;
    logic [NUM_QW-1:0][QW_W-1:0] shr_q;
    logic [NUM_QW-1:0][QW_W-1:0] perm_q;

    assign src1 = q.rf[I_OP_SRC1];
    assign src2 = q.rf[I_OP_SRC2];

    // counts are full element wide, so any high count bit means oversize
    for (genvar g = 0; g < NUM_DW; g++) begin : g_dw
        logic [DW_W-1:0] a;
        logic [DW_W-1:0] c;
        logic big;
        assign a = src1[g*DW_W +: DW_W];
        assign c = src2[g*DW_W +: DW_W];
        assign big = |c[DW_W-1:5];
        assign shl_d[g] = big ? '0 : a << c[4:0];
        assign shr_d[g] = big ? '0 : a >> c[4:0];
        assign sar_d[g] = big ? {DW_W{a[DW_W-1]}} :
                          DW_W'($signed(a) >>> c[4:0]);
        // index from src1, data from src2
        assign perm_d[g] = src2[{a[2:0], 5'h00} +: DW_W];
    end

    for (genvar g = 0; g < NUM_QW; g++) begin : g_qw
        logic [QW_W-1:0] a;
        logic [QW_W-1:0] c;
        logic big;
        assign a = src1[g*QW_W +: QW_W];
        assign c = src2[g*QW_W +: QW_W];
        assign big = |c[QW_W-1:6];
        assign shl_q[g] = big ? '0 : a << c[5:0];
        assign shr_q[g] = big ? '0 : a >> c[5:0];
        assign perm_q[g] =
            src1[{I_OP_IMM[2*g +: 2], 6'h00} +: QW_W];
    end

    // final register value from a new result, by encoding and length
    function automatic logic [VEC_W-1:0] merge_width(
        input logic [VEC_W-1:0] old_v,
        input logic [VEC_W-1:0] new_v,
        input logic full,
        input logic newpfx
    );
        logic [VEC_W-1:0] r;
        r = new_v;
        if (!full) begin
            if (newpfx) begin
                r[VEC_W-1:HALF_W] = '0;
            end else begin
                r[VEC_W-1:HALF_W] = old_v[VEC_W-1:HALF_W];
            end
        end
        return r;
    endfunction

    always_comb begin
        logic g_is;
        logic g_idx64;
        logic g_dat64;
        logic full;
        logic [3:0] nelem;
        logic [VEC_W-1:0] ivec;
        logic [VEC_W-1:0] mvec;
        logic [QW_W-1:0] idx;
        logic en;
        logic [VEC_W-1:0] r;
        vop_t op;

        d = q;
        g_is = 1'b0;
        g_idx64 = 1'b0;
        g_dat64 = 1'b0;
        full = 1'b0;
        nelem = GATH_N_128_NARROW;
        ivec = '0;
        mvec = '0;
        idx = '0;
        en = 1'b0;
        r = '0;
        d.done = 1'b0;
        op = (q.st == S_IDLE) ? I_OP_CODE : q.op;

        case (op)
            GATHER_I32IDX_I32,
            GATHER_I32IDX_FP32: begin
                g_is = 1'b1;
            end
            GATHER_I64IDX_I32,
            GATHER_I64IDX_FP32: begin
                g_is = 1'b1;
                g_idx64 = 1'b1;
            end
            GATHER_I32IDX_FP64,
            GATHER_I32IDX_I64: begin
                g_is = 1'b1;
                g_dat64 = 1'b1;
            end
            GATHER_I64IDX_FP64,
            GATHER_I64IDX_I64: begin
                g_is = 1'b1;
                g_idx64 = 1'b1;
                g_dat64 = 1'b1;
            end
            default: begin
                g_is = 1'b0;
            end
        endcase

        case (q.st)
            S_IDLE: begin
                if (I_OP_VALID) begin
                    d.op = I_OP_CODE;
                    d.newpfx = I_OP_NEWPFX;
                    d.vl256 = I_OP_VL256;
                    d.dst = I_OP_DST;
                    d.idx_reg = I_OP_SRC1;
                    d.mask_reg = I_OP_MASK;
                    d.base = I_OP_BASE;
                    d.scale = I_OP_SCALE;
                    d.elem = '0;
                    if (g_is) begin
                        d.gacc = q.rf[I_OP_DST];
                        d.st = S_GATHER;
                    end else begin
                        // cross-lane permutes exist only at full length
                        full = I_OP_VL256 && I_OP_NEWPFX;
                        case (I_OP_CODE)
                            OP_LOAD: r = I_OP_DATA;
                            VAR_SHL_DWORD: r = shl_d;
                            VAR_SHL_QWORD: r = shl_q;
                            VAR_SAR_DWORD: r = sar_d;
                            VAR_SHR_DWORD: r = shr_d;
                            VAR_SHR_QWORD: r = shr_q;
                            PERM_INT32_INDEXED,
                            PERM_FP32_INDEXED: begin
                                r = perm_d;
                                full = 1'b1;
                            end
                            PERM_INT64_IMMEDIATE,
                            PERM_FP64_IMMEDIATE: begin
                                r = perm_q;
                                full = 1'b1;
                            end
                            default: r = q.rf[I_OP_DST];
                        endcase
                        // a 128-bit write keeps the old top half, or zeroes it under the new prefix
                        r = merge_width(q.rf[I_OP_DST], r, full,
                                        I_OP_NEWPFX);
                        d.rf[I_OP_DST] = r;
                        d.res = r;
                        d.done = 1'b1;
                    end
                end
            end
            S_GATHER: begin
                ivec = q.rf[q.idx_reg];
                mvec = q.rf[q.mask_reg];
                if (q.vl256) begin
                    nelem = (g_idx64 || g_dat64) ? GATH_N_256_WIDE :
                                                   GATH_N_256_NARROW;
                end else begin
                    nelem = (g_idx64 || g_dat64) ? GATH_N_128_WIDE :
                                                   GATH_N_128_NARROW;
                end
                if (g_idx64) begin
                    idx = ivec[{q.elem[1:0], 6'h00} +: QW_W];
                end else begin
                    idx = QW_W'($signed(ivec[{q.elem[2:0], 5'h00}
                                              +: DW_W]));
                end
                // enable is the sign bit of the matching mask element
                if (g_dat64) begin
                    en = mvec[{q.elem[1:0], 6'h3F}];
                end else begin
                    en = mvec[{q.elem[2:0], 5'h1F}];
                end
                if (q.mem_req) begin
                    if (I_MEM_ACK) begin
                        if (g_dat64) begin
                            d.gacc[{q.elem[1:0], 6'h00} +: QW_W] =
                                I_MEM_DATA;
                        end else begin
                            d.gacc[{q.elem[2:0], 5'h00} +: DW_W] =
                                I_MEM_DATA[DW_W-1:0];
                        end
                        d.mem_req = 1'b0;
                        d.elem = q.elem + 4'h1;
                    end
                end else if (q.elem == nelem) begin
                    // qword-index dword gather fills only a 128-bit dest
                    full = q.vl256 && !(g_idx64 && !g_dat64);
                    r = merge_width(q.rf[q.dst], q.gacc, full, q.newpfx);
                    d.rf[q.dst] = r;
                    d.res = r;
                    d.done = 1'b1;
                    d.st = S_IDLE;
                end else if (en) begin
                    d.mem_req = 1'b1;
                    d.mem_addr = q.base + (idx << q.scale);
                    d.mem_size64 = g_dat64;
                end else begin
                    // disabled element: accumulator keeps the old value
                    d.elem = q.elem + 4'h1;
                end
            end
            default: begin
                d.st = S_IDLE;
            end
        endcase

        d.ready = (d.st == S_IDLE);

        d.id_valid = I_ID_REQ;
        if (I_ID_REQ) begin
            if (I_ID_LEAF == ID_LEAF_EXT_FEAT &&
                I_ID_SUBLEAF == ID_SUBLEAF_MAIN) begin
                d.id_ebx = 32'h0000_0001 << ID_FEAT_BIT;
            end else begin
                d.id_ebx = ID_EBX_NONE;
            end
        end

        // restore is applied last so it wins over a same-cycle result
        d.xs_valid = I_XS_REQ;
        if (I_XS_REQ) begin
            if (I_XS_WRITE) begin
                d.rf[I_XS_IDX][VEC_W-1:HALF_W] = I_XS_WDATA;
            end
            d.xs_rdata = q.rf[I_XS_IDX][VEC_W-1:HALF_W];
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_SRST) begin
            q <= '0;
            q.rf <= {NUM_VREG{VREG_RST}};
            q.ready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign O_OP_READY = q.ready;
    assign O_OP_DONE = q.done;
    assign O_RES_DATA = q.res;
    assign O_MEM_REQ = q.mem_req;
    assign O_MEM_ADDR = q.mem_addr;
    assign O_MEM_SIZE64 = q.mem_size64;
    assign O_ID_VALID = q.id_valid;
    assign O_ID_EBX = q.id_ebx;
    assign O_XS_VALID = q.xs_valid;
    assign O_XS_RDATA = q.xs_rdata;

endmodule

// ### vpsg_sva.sv
`timescale 1ns/1ps
module vpsg_sva
    import vec_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_SRST,
    input wire logic I_OP_VALID,
    input wire vop_t I_OP_CODE,
    input wire logic O_OP_READY,
    input wire logic O_OP_DONE,
    input wire logic [VEC_W-1:0] O_RES_DATA,
    input wire logic O_MEM_REQ,
    input wire logic [ADDR_W-1:0] O_MEM_ADDR,
    input wire logic I_MEM_ACK,
    input wire logic I_ID_REQ,
    input wire logic [31:0] I_ID_LEAF,
    input wire logic [31:0] I_ID_SUBLEAF,
    input wire logic O_ID_VALID,
    input wire logic [31:0] O_ID_EBX,
    input wire logic I_XS_REQ,
    input wire logic O_XS_VALID
);
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (I_SRST);
    wire take = I_OP_VALID && O_OP_READY;
    wire gath = I_OP_CODE >= GATHER_I32IDX_I32;
    a_op_done: assert property (take && !gath |=> O_OP_DONE)
        else $error("op result not in next cycle");
    a_gath_busy: assert property (take && gath |=> !O_OP_READY [*2])
        else $error("ready during gather");
    a_gath_bound: assert property (take && gath |->
        ##[3:400] O_OP_DONE) else $error("gather never finished");
    a_req_hold: assert property (O_MEM_REQ && !I_MEM_ACK
        |=> O_MEM_REQ && $stable(O_MEM_ADDR)) else $error("request dropped");
    a_req_gap: assert property (O_MEM_REQ && I_MEM_ACK
        |=> !O_MEM_REQ) else $error("requests back to back");
    a_idle_noreq: assert property (O_OP_READY |-> !O_MEM_REQ)
        else $error("memory request while idle");
    a_id_feature: assert property (I_ID_REQ |=> O_ID_VALID &&
        O_ID_EBX == (($past(I_ID_LEAF) == ID_LEAF_EXT_FEAT &&
        $past(I_ID_SUBLEAF) == ID_SUBLEAF_MAIN) ? 32'h0000_0020 :
        32'h0000_0000)) else $error("feature word wrong");
    a_xs_answer: assert property (I_XS_REQ |=> O_XS_VALID)
        else $error("save access not answered");
    a_res_hold: assert property (!O_OP_DONE |->
        $stable(O_RES_DATA)) else $error("result moved without done");
endmodule

bind vector_permute_shift_gather vpsg_sva u_sva (
    .I_CLK_SYS(I_CLK_SYS), .I_SRST(I_SRST), .I_OP_VALID(I_OP_VALID),
    .I_OP_CODE(I_OP_CODE), .O_OP_READY(O_OP_READY), .O_OP_DONE(O_OP_DONE),
    .O_RES_DATA(O_RES_DATA), .O_MEM_REQ(O_MEM_REQ), .O_MEM_ADDR(O_MEM_ADDR),
    .I_MEM_ACK(I_MEM_ACK), .I_ID_REQ(I_ID_REQ), .I_ID_LEAF(I_ID_LEAF),
    .I_ID_SUBLEAF(I_ID_SUBLEAF), .O_ID_VALID(O_ID_VALID),
    .O_ID_EBX(O_ID_EBX), .I_XS_REQ(I_XS_REQ), .O_XS_VALID(O_XS_VALID));

// ### mem_partner.sv
`timescale 1ns/1ps
module mem_partner
    import vec_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic size64,
    input wire logic req,
    input wire logic [ADDR_W-1:0] addr,
    output logic ack,
    output logic [QW_W-1:0] rdata
);
    logic [2:0] wait_q;
    // data churns after each ack and while no request is pending, so a late sample cannot pass
    always_ff @(posedge clk) begin
        if (rst || ack || !req) begin
            ack <= 1'b0;
            wait_q <= 3'h0;
            rdata <= rst ? 64'h0000_0000_0000_0000 : {rdata[62:0], ~rdata[63]};
        end else if (!slow || wait_q == 3'h5) begin
            ack <= 1'b1;
            // a 4-byte answer differs in its low word, so a wrong size shows
            rdata <= size64 ? {addr[31:0] ^ 32'hFFFF_0000, addr[31:0]} :
                              {32'h0000_0000, addr[31:0] ^ 32'h0000_FFFF};
        end else begin
            wait_q <= wait_q + 3'h1;
        end
    end
endmodule

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
    import vec_pkg::*;
    logic clk = 0, rst = 1, vld = 0, npf = 1, v256 = 1, slow = 0;
    logic done, mreq, ack, idreq = 0, idv, xreq = 0, xwr = 0, xv, msz;
    vop_t code = OP_LOAD;
    logic [3:0] dst = 0, s1 = 0, s2 = 0, msk = 0, xidx = 4'hA;
    logic [7:0] imm = 0;
    logic [1:0] scl = 0;
    logic [63:0] base = 0, maddr, mdat;
    logic [255:0] data = 0, rd;
    logic [31:0] leaf = 0, sub = 0, ebx;
    logic [127:0] xwd = 0, xrd;
    int err_total = 0, n_tests = 0, cyc = 0;
    always #5 clk = ~clk;
    vector_permute_shift_gather dut (
        .I_CLK_SYS(clk), .I_SRST(rst), .I_OP_VALID(vld), .I_OP_CODE(code),
        .I_OP_NEWPFX(npf), .I_OP_VL256(v256), .I_OP_DST(dst), .I_OP_SRC1(s1),
        .I_OP_SRC2(s2), .I_OP_MASK(msk), .I_OP_IMM(imm), .I_OP_BASE(base),
        .I_OP_SCALE(scl), .I_OP_DATA(data), .O_OP_READY(), .O_OP_DONE(done),
        .O_RES_DATA(rd), .O_MEM_REQ(mreq), .O_MEM_ADDR(maddr),
        .O_MEM_SIZE64(msz), .I_MEM_ACK(ack), .I_MEM_DATA(mdat),
        .I_ID_REQ(idreq), .I_ID_LEAF(leaf), .I_ID_SUBLEAF(sub),
        .O_ID_VALID(idv), .O_ID_EBX(ebx), .I_XS_REQ(xreq), .I_XS_WRITE(xwr),
        .I_XS_IDX(xidx), .I_XS_WDATA(xwd), .O_XS_VALID(xv), .O_XS_RDATA(xrd));
    mem_partner mem (.clk(clk), .rst(rst), .slow(slow), .size64(msz),
        .req(mreq), .addr(maddr), .ack(ack), .rdata(mdat));
    task automatic conclude();
        if (err_total == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            conclude();
        end
    end
    task automatic chk(input logic [255:0] got, input logic [255:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic run(input vop_t c);
        int k;
        @(posedge clk);
        code <= c;
        vld <= 1'b1;
        @(posedge clk);
        vld <= 1'b0;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (done !== 1'b1 && k < 500);
        chk(256'(done), 256'h1);
        // hand back on a rising edge so callers drive inputs there
        @(posedge clk);
    endtask
    task automatic ld(input logic [3:0] r, input logic [255:0] v);
        dst <= r;
        data <= v;
        npf <= 1'b1;
        v256 <= 1'b1;
        run(OP_LOAD);
        chk(rd, v);
    endtask
    function automatic logic [255:0] shx(vop_t c, logic [255:0] a, n);
        logic [255:0] r;
        logic [31:0] d, s;
        logic [63:0] e, t;
        for (int i = 0; i < 8; i++) begin
            d = a[32*i+:32];
            s = n[32*i+:32];
            if (c == VAR_SHL_DWORD) r[32*i+:32] = s > 31 ? 32'h0 : d << s;
            if (c == VAR_SHR_DWORD) r[32*i+:32] = s > 31 ? 32'h0 : d >> s;
            if (c == VAR_SAR_DWORD)
                r[32*i+:32] = $signed(d) >>> (s > 31 ? 31 : s);
        end
        for (int i = 0; i < 4; i++) begin
            e = a[64*i+:64];
            t = n[64*i+:64];
            if (c == VAR_SHL_QWORD) r[64*i+:64] = t > 63 ? 64'h0 : e << t;
            if (c == VAR_SHR_QWORD) r[64*i+:64] = t > 63 ? 64'h0 : e >> t;
        end
        return r;
    endfunction
    task automatic t_shift();
        logic [255:0] a, n, o, x;
        vop_t c;
        a = {4{64'h8000_00F1_1234_5678}};
        // counts sit on both sides of the element widths
        n = {64'h0000_0000_0000_0040, 64'h0000_0000_0000_003F,
             64'h0000_0000_0000_0028, 64'h0000_0000_0000_0003};
        o = {8{32'hC3C3_5A5A}};
        ld(4'h1, a);
        ld(4'h2, n);
        for (int k = 0; k < 7; k++) begin
            c = vop_t'(VAR_SHL_DWORD + (k * 2) % 5);
            ld(4'h3, o);
            npf <= k != 5;
            v256 <= k < 5;
            s1 <= 4'h1;
            s2 <= 4'h2;
            run(c);
            x = shx(c, a, n);
            if (k > 4) x[255:128] = k == 5 ? o[255:128] : 128'h0;
            chk(rd, x);
        end
    endtask
    task automatic t_perm();
        logic [255:0] d, ix, x;
        for (int i = 0; i < 8; i++) begin
            d[32*i+:32] = 32'hA000_0000 + i;
            ix[32*i+:32] = (i * 3 + 1) % 8;
        end
        ld(4'h4, d);
        ld(4'h5, ix);
        for (int k = 0; k < 4; k++) begin
            s1 <= (k == 0 || k == 3) ? 4'h5 : 4'h4;
            s2 <= 4'h4;
            dst <= 4'h6;
            imm <= 8'hC6;
            run(vop_t'(PERM_INT32_INDEXED + k));
            for (int i = 0; i < 8; i++) x[32*i+:32] = d[32*ix[32*i+:3]+:32];
            for (int i = 0; i < 4 && (k == 1 || k == 2); i++)
                x[64*i+:64] = d[64*((8'hC6 >> 2*i) % 4)+:64];
            chk(rd, x);
        end
    endtask
    task automatic t_gath();
        logic [255:0] ix, mk, o, x;
        logic [63:0] a, ex;
        logic q, i64;
        int n;
        for (int i = 0; i < 8; i++) begin
            ix[32*i+:32] = 32'(i * 4 - 8);
            mk[32*i+:32] = i % 3 != 1 ? 32'h8000_0000 : 32'h7FFF_FFFF;
        end
        o = {8{32'hC3C3_5A5A}};
        ld(4'h7, ix);
        ld(4'h8, mk);
        for (int k = 0; k < 16; k++) begin
            q = k[1];
            i64 = k[0];
            ld(4'h9, o);
            v256 <= k < 8;
            slow <= k[2];
            s1 <= 4'h7;
            msk <= 4'h8;
            base <= 64'h0000_1000_0000_0000;
            scl <= 2'(k % 4);
            run(vop_t'(GATHER_I32IDX_I32 + k % 8));
            n = ((q || i64) ? 2 : 4) * (k < 8 ? 2 : 1);
            // elements past the count keep the old destination value
            x = o;
            for (int j = 0; j < n; j++) begin
                a = i64 ? ix[64*j+:64] : {{32{ix[32*j+31]}}, ix[32*j+:32]};
                a = 64'h0000_1000_0000_0000 + (a << (k % 4));
                ex = {a[31:0] ^ 32'hFFFF_0000, a[31:0]};
                // a 4-byte answer carries a different low word
                if (q) x[64*j+:64] = mk[64*j+63] ? ex : o[64*j+:64];
                else x[32*j+:32] = mk[32*j+31] ?
                    a[31:0] ^ 32'h0000_FFFF : o[32*j+:32];
            end
            // 128-bit forms and the narrow qword-index form zero the top
            if (k > 7 || (i64 && !q)) x[255:128] = '0;
            chk(rd, x);
        end
    endtask
    task automatic t_id();
        logic [31:0] e;
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            idreq <= 1'b1;
            leaf <= k < 2 ? ID_LEAF_EXT_FEAT : 32'h0000_0001;
            sub <= {31'h0, k == 1};
            @(posedge clk);
            idreq <= 1'b0;
            @(negedge clk);
            e = k == 0 ? 32'h0000_0001 << ID_FEAT_BIT : 32'h0000_0000;
            chk(256'({idv, ebx}), 256'({1'b1, e}));
        end
        @(posedge clk);
    endtask
    task automatic xs(input logic w, input logic [127:0] d, e);
        @(posedge clk);
        xreq <= 1'b1;
        xwr <= w;
        xwd <= d;
        @(posedge clk);
        xreq <= 1'b0;
        @(negedge clk);
        chk(256'({xv, xrd}), 256'({1'b1, e}));
        @(posedge clk);
    endtask
    task automatic t_xs();
        logic [255:0] v;
        v = {8{32'h1357_9BDF}};
        v[255:224] = 32'h2468_ACE0;
        ld(4'hA, v);
        xs(1'b1, {4{32'h5A5A_A5A5}}, v[255:128]);
        xs(1'b0, 128'h0, {4{32'h5A5A_A5A5}});
        s1 <= 4'hA;
        dst <= 4'hB;
        imm <= 8'hE4;
        run(PERM_INT64_IMMEDIATE);
        chk(rd, {{4{32'h5A5A_A5A5}}, v[127:0]});
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_id();
        t_shift();
        t_perm();
        t_gath();
        t_xs();
        conclude();
    end
endmodule
